// ===== rtl/rco_refclk_gen.sv
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
// Function
// - Divide source by twice the divider field
// - Enable bit turns the module on
// - Stop-in-idle halts module during Idle
// - Output enable drives the clock pin
// - Run-in-sleep keeps output toggling in Sleep
// - Run-in-sleep ignored for system/bus clocks
// - Switch bit reads one until switch completes
// - Request status bit is hardware owned
// - While on, new divider and source wait for switch
// - Source select picks one of nine sources
// - Unimplemented register bits read zero
// - Tuning writes need the unlock sequence
// - Trim holds nine bits at the top
// - While on, trim writes wait for switch
module rco_refclk_gen import rco_pkg::*; (
  // Clock, reset and enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Power state from the same clock domain
  input  wire logic              idle_mode,
  input  wire logic              sleep_mode,
  // Clock sources, indexed by source select code
  input  wire logic [NSRC-1:0]   src_clocks,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // Reference clock pin
  output logic                   reference_clock_output_pin,
  output logic                   ref_pin_oe_n,
  // Settings for the oscillators
  output logic [TUNE_W-1:0]      fast_rc_tune,
  output logic [TRIM_W-1:0]      ref_trim
);

  // Everything the block remembers except the reset synchroniser and the divider lives in one
  // packed record, so the one register process is its only store and the clock
  // enable freezes all of it at once. Fields ending in _sw hold what software
  // last wrote; fields ending in _eff hold what is really in use. They
  // differ only while the module is on, from a write until a switch completes.
  // All generator state
  typedef struct packed {
    logic [NSRC-1:0]   s1;        // Source synchroniser, first stage
    logic [NSRC-1:0]   s2;        // Source synchroniser, second stage
    logic              lvl;       // Selected source level, last cycle
    logic              dph_wr;    // Write data phase pending
    logic              dph_rd;    // Read data phase pending
    logic [3:0]        dph_ofs;   // Offset of the data phase
    logic [31:0]       rdata;     // Read data
    logic              rdy;       // Ready to bus
    logic [TUNE_W-1:0] tune;      // Fast RC tuning value
    logic              key1;      // First unlock key seen
    logic              unlocked;  // One tuning write allowed
    logic              on;        // Module enable
    logic              stop_in_idle;      // Stop in idle
    logic              oe;        // Output drive enable
    logic              run_in_sleep;      // Run in sleep
    logic              sw;        // Divider switch request
    logic              act;       // Request status
    logic [DIV_W-1:0]  div_sw;    // Divider as written
    logic [DIV_W-1:0]  div_eff;   // Divider in use
    logic [SEL_W-1:0]  sel_sw;    // Source as written
    logic [SEL_W-1:0]  sel_eff;   // Source in use
    logic [TRIM_W-1:0] trim_sw;   // Trim as written
    logic [TRIM_W-1:0] trim_eff;  // Trim in use
    logic              pin;       // Pin level
    logic              pin_oe_n;  // Pin drive enable, active low
  } rco_state_t;

  rco_state_t  st_q;        // Registered state
  rco_state_t  st_d;        // Next state
  logic [1:0]  rst_sync_q;  // Reset release synchroniser
  logic        rst_int_n;   // Synchronised reset
  logic        run;         // Module running this cycle
  logic        lvl_sel;     // Selected source level
  logic        take;        // Address phase accepted
  logic        sw_set;      // Software sets the switch bit
  logic [15:0] src_pad;     // Sources padded to all select codes

  rco_div_if dif ();  // Divider link

  // System and bus clocks are themselves stopped in Sleep, so the
  // run-in-sleep bit cannot keep these two sources alive
  // True for the two clocks that always stop in Sleep
  function automatic logic fast_src(input logic [SEL_W-1:0] sel);
    return (sel == SEL_SYS) || (sel == SEL_PB);
  endfunction

  // Reads show what software wrote, not the settings in use, so a
  // pending switch shows up as readback differing from behaviour.
  // Unlock keys are write-only; unmapped offsets read as zero.
  // Register read view
  function automatic logic [31:0] rd_word(input rco_state_t s, input logic [3:0] ofs);
    logic [31:0] w;
    w = REG_RST;
    unique case (ofs)
      OFS_TUNE: begin
        w[TUNE_W-1:0] = s.tune;                       // Upper bits zero
      end
      OFS_CTRL: begin
        w[CTRL_DIV_MSB:CTRL_DIV_LSB] = s.div_sw;
        w[CTRL_ON]                   = s.on;
        w[CTRL_STOP_IN_IDLE]                 = s.stop_in_idle;
        w[CTRL_OE]                   = s.oe;
        w[CTRL_RUN_IN_SLEEP]                 = s.run_in_sleep;
        w[CTRL_SW]                   = s.sw;
        w[CTRL_ACT]                  = s.act;
        w[SEL_W-1:0]                 = s.sel_sw;      // Gaps stay zero
      end
      OFS_TRIM: begin
        w[31:TRIM_LSB] = s.trim_sw;                   // Low bits zero
      end
      default: begin
        w = REG_RST;                                  // Unlock and unmapped read zero
      end
    endcase
    return w;
  endfunction

  // Reset asserts at once but lifts on a clock edge two flops later,
  // so every flop leaves reset in the same cycle
  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  // Source clocks are asynchronous and pass two flops first. A source
  // faster than half of clk aliases and is counted wrongly.
  // Source mux; reserved codes select a constant low
  assign src_pad = {{(16-NSRC){1'b0}}, st_q.s2};
  assign lvl_sel = src_pad[st_q.sel_eff];

  // Power state inputs come from this clock domain, no synchroniser.
  // A halted module drives its pin low and restarts the divider.
  // Running: on, not stopped by Idle, not stopped by Sleep
  assign run = st_q.on
             & ~(idle_mode & st_q.stop_in_idle)
             & ~(sleep_mode & (~st_q.run_in_sleep | fast_src(st_q.sel_eff)));

  // A rising source edge against last cycle's level gives a one-cycle
  // tick that the divider counts
  // Divider link
  assign dif.level = lvl_sel;
  assign dif.tick  = lvl_sel & ~st_q.lvl;
  assign dif.run   = run;
  assign dif.div   = st_q.div_eff;

  // Zero wait states: a valid address phase is always taken and its
  // data phase follows in the next cycle
  // Address phase accepted
  assign take = hsel & htrans[1] & hready;

  // A written zero has no effect; the bit clears on completion or when the module is turned off
  // Software write of a one to the switch bit
  assign sw_set = st_q.dph_wr & (st_q.dph_ofs == OFS_CTRL) & hwdata[CTRL_SW];

  // Next-state logic
  always_comb begin
    st_d = st_q;
    // Fields not named below keep their value through the copy
    // Source synchronisers and edge history
    st_d.s1  = src_clocks;
    st_d.s2  = st_q.s1;
    st_d.lvl = lvl_sel;
    // Registered one cycle late, like the other status bits
    // Request status follows the running state
    st_d.act = run;
    // Write data stands one cycle after the address naming it
    // Register writes in the data phase
    if (st_q.dph_wr) begin
      unique case (st_q.dph_ofs)
        OFS_CTRL: begin
          st_d.div_sw = hwdata[CTRL_DIV_MSB:CTRL_DIV_LSB];
          st_d.on     = hwdata[CTRL_ON];
          st_d.stop_in_idle   = hwdata[CTRL_STOP_IN_IDLE];
          st_d.oe     = hwdata[CTRL_OE];
          st_d.run_in_sleep   = hwdata[CTRL_RUN_IN_SLEEP];
          st_d.sel_sw = hwdata[SEL_W-1:0];
        end
        OFS_TRIM: begin
          st_d.trim_sw = hwdata[31:TRIM_LSB];
        end
        OFS_TUNE: begin
          if (st_q.unlocked) begin
            st_d.tune     = hwdata[TUNE_W-1:0];
            st_d.unlocked = 1'b0;
          end
        end
        OFS_UNLK: begin
          st_d.key1     = (hwdata == UNLK_KEY1);
          st_d.unlocked = st_q.key1 & (hwdata == UNLK_KEY2);
        end
        default: begin
          st_d.rdy = 1'b1;                            // Unmapped write ignored
        end
      endcase
    end
    // Switch handshake. While off, written settings pass straight on.
    // While on they wait for the switch bit, then load only at the end
    // of an output period so the pin never shows a runt pulse. A halted
    // module has no period to finish and loads at once. A new request
    // in the completion cycle wins and keeps the bit set.
    // Settings take effect directly while off
    if (!st_d.on) begin
      st_d.div_eff  = st_d.div_sw;
      st_d.sel_eff  = st_d.sel_sw;
      st_d.trim_eff = st_d.trim_sw;
      st_d.sw       = 1'b0;
    end else if (sw_set) begin
      st_d.sw = 1'b1;                                 // Set wins over completion
    end else if (st_q.sw && (dif.boundary || !run)) begin
      st_d.div_eff  = st_d.div_sw;
      st_d.sel_eff  = st_d.sel_sw;
      st_d.trim_eff = st_d.trim_sw;
      st_d.sw       = 1'b0;
    end
    // Read data comes from the next state, so a read right after a
    // write to the same register already sees the new value
    // Next data phase
    st_d.rdy     = 1'b1;
    st_d.dph_wr  = take & hwrite;
    st_d.dph_rd  = take & ~hwrite;
    st_d.dph_ofs = (haddr[31:4] == 28'h0) ? haddr[3:0] : OFS_NONE;
    st_d.rdata   = (take & ~hwrite) ? rd_word(st_d, st_d.dph_ofs) : REG_RST;
    // Drive enable follows on and output enable only, so a halted
    // module holds its pin low instead of letting it float
    // Pin follows the divider while driven
    st_d.pin      = run & st_q.oe & dif.out;
    st_d.pin_oe_n = ~(st_q.on & st_q.oe);
  end

  // Reset values make the bus ready and the pin undriven from the
  // first edge, before any software access
  // State register
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_q          <= '0;
      st_q.rdy      <= 1'b1;
      st_q.pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // Runs from the same synchronised reset and clock enable
  // Divider
  rco_divider u_div (
    .clk    (clk),
    .rst_n  (rst_int_n),
    .clk_en (clk_en),
    .dif    (dif.dv)
  );

  // Outputs come from state flops; the response is a constant OKAY
  // because no access is ever refused
  // Outputs
  assign hreadyout                  = st_q.rdy;
  assign hrdata                     = st_q.rdata;
  assign hresp                      = HRESP_OKAY;
  assign reference_clock_output_pin = st_q.pin;
  assign ref_pin_oe_n               = st_q.pin_oe_n;
  assign fast_rc_tune               = st_q.tune;
  assign ref_trim                   = st_q.trim_eff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_int_n);

  // Checks on readback, settings hold-off, halting and pin drive
  // Helper: write to the tuning register in this cycle
  logic wr_tune;
  assign wr_tune = st_q.dph_wr && (st_q.dph_ofs == OFS_TUNE);

  AST_CTRL_RSV: assert property (st_q.dph_rd && st_q.dph_ofs == OFS_CTRL
    |-> (hrdata & CTRL_RSV_MASK) == 32'h0) else $error("control gap bits set");
  AST_TUNE_RSV: assert property (st_q.dph_rd && st_q.dph_ofs == OFS_TUNE
    |-> hrdata[31:TUNE_W] == 26'h0) else $error("tuning upper bits set");
  AST_TRIM_RSV: assert property (st_q.dph_rd && st_q.dph_ofs == OFS_TRIM
    |-> hrdata[TRIM_LSB-1:0] == 23'h0) else $error("trim low bits set");
  AST_DIV_HELD: assert property (clk_en && st_q.on && !st_q.sw
    |=> !st_q.on || ($stable(st_q.div_eff) && $stable(st_q.sel_eff)))
    else $error("setting changed without switch");
  AST_TRIM_HELD: assert property (clk_en && st_q.on && !st_q.sw
    |=> !st_q.on || $stable(st_q.trim_eff)) else $error("trim changed without switch");
  AST_SW_DONE: assert property (clk_en && st_q.sw && !run && !sw_set
    |=> !st_q.sw) else $error("halted switch not completed");
  AST_OFF: assert property (clk_en && !st_q.on
    |=> !st_q.act && !st_q.pin) else $error("module active while off");
  AST_IDLE_STOP: assert property (clk_en && idle_mode && st_q.stop_in_idle
    |=> !st_q.act) else $error("running in idle with stop set");
  AST_SLEEP_RUN: assert property (clk_en && sleep_mode && !idle_mode && st_q.on && st_q.run_in_sleep
    && !fast_src(st_q.sel_eff) |=> st_q.act) else $error("stopped in sleep");
  AST_SLEEP_FAST: assert property (clk_en && sleep_mode && fast_src(st_q.sel_eff)
    |=> !st_q.act) else $error("bus clock source ran in sleep");
  AST_PIN_OE: assert property (clk_en && !st_q.oe
    |=> st_q.pin_oe_n && !st_q.pin) else $error("pin driven while disabled");
  AST_TUNE_LOCK: assert property (clk_en && wr_tune && !st_q.unlocked
    |=> $stable(st_q.tune)) else $error("locked tuning written");
  AST_RSVD_SRC: assert property (st_q.sel_eff > SEL_EXT
    |-> !lvl_sel) else $error("reserved source not silent");

  AST_ACT_RUN: assert property (clk_en |=> st_q.act == $past(run))
    else $error("request status does not follow running state");
  AST_OE_ON: assert property (clk_en && st_q.on && st_q.oe |=> !st_q.pin_oe_n)
    else $error("pin not driven while enabled");
  AST_PIN_HALT: assert property (clk_en && !run |=> !st_q.pin)
    else $error("pin toggles while halted");
  AST_SW_WAIT: assert property (clk_en && st_q.sw && run && !dif.boundary && st_d.on
    |=> st_q.sw) else $error("switch completed before period end");

  // Coverage of the switch, unlock, pin and Sleep paths
  // Main scenarios
  COV_SWITCH: cover property (st_q.on && st_q.sw ##1 !st_q.sw);
  COV_TUNE: cover property (clk_en && wr_tune && st_q.unlocked);
  COV_PIN: cover property (!st_q.pin ##1 st_q.pin);
  COV_SLEEP: cover property (sleep_mode && st_q.act);

endmodule // rco_refclk_gen

// ===== rtl/rco_pkg.sv
// Shared constants for the reference clock output generator
package rco_pkg;

  // Register byte offsets (haddr[3:0])
  localparam logic [3:0]  OFS_TUNE      = 4'h0;  // Fast RC tuning
  localparam logic [3:0]  OFS_CTRL      = 4'h4;  // Reference clock control
  localparam logic [3:0]  OFS_TRIM      = 4'h8;  // Reference clock trim
  localparam logic [3:0]  OFS_UNLK      = 4'hc;  // Oscillator unlock keys
  localparam logic [3:0]  OFS_NONE      = 4'h3;  // Decodes to no register

  // Field widths
  localparam int          DIV_W         = 15;
  localparam int          SEL_W         = 4;
  localparam int          TUNE_W        = 6;
  localparam int          TRIM_W        = 9;
  localparam int          NSRC          = 9;

  // Control register field positions
  localparam int          CTRL_DIV_LSB  = 16;
  localparam int          CTRL_DIV_MSB  = 30;
  localparam int          CTRL_ON       = 15;
  localparam int          CTRL_STOP_IN_IDLE     = 13;
  localparam int          CTRL_OE       = 12;
  localparam int          CTRL_RUN_IN_SLEEP     = 11;
  localparam int          CTRL_SW       = 9;
  localparam int          CTRL_ACT      = 8;
  localparam logic [31:0] CTRL_RSV_MASK = 32'h8000_44f0;

  // Trim register field position
  localparam int          TRIM_LSB      = 23;

  // Source select codes
  localparam logic [3:0]  SEL_SYS       = 4'h0;  // System clock
  localparam logic [3:0]  SEL_PB        = 4'h1;  // Peripheral bus clock
  localparam logic [3:0]  SEL_POSC      = 4'h2;  // Primary oscillator
  localparam logic [3:0]  SEL_FRC       = 4'h3;  // Fast RC
  localparam logic [3:0]  SEL_LOW_POWER_RC_OSCILLATOR      = 4'h4;  // Low-power RC
  localparam logic [3:0]  SEL_SOSC      = 4'h5;  // Secondary oscillator
  localparam logic [3:0]  SEL_UPLL      = 4'h6;  // USB PLL
  localparam logic [3:0]  SEL_SPLL      = 4'h7;  // System PLL
  localparam logic [3:0]  SEL_EXT       = 4'h8;  // External reference input

  // Unlock keys, values arbitrary
  localparam logic [31:0] UNLK_KEY1     = 32'h0000_5a5a;
  localparam logic [31:0] UNLK_KEY2     = 32'h0000_a5a5;

  // Reset values
  localparam logic [31:0] REG_RST       = 32'h0000_0000;

  // Bus encodings
  localparam logic        HRESP_OKAY    = 1'b0;

endpackage

// ===== rtl/rco_div_if.sv
`timescale 1ns/10ps
// Control and result signals between the generator and its divider
interface rco_div_if;
  import rco_pkg::*;
  logic             level;     // Selected, synchronised source level
  logic             tick;      // One-cycle pulse on a source rising edge
  logic             run;       // Divider may run
  logic [DIV_W-1:0] div;       // Effective divider field
  logic             out;       // Divided clock
  logic             boundary;  // End of an output period
  modport ctl (output level, tick, run, div, input out, boundary);
  modport dv  (input level, tick, run, div, output out, boundary);
endinterface

// ===== rtl/rco_divider.sv
`timescale 1ns/10ps
// Even divider: toggles every div source edges, passes through at zero
module rco_divider import rco_pkg::*; (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Divider link
  rco_div_if.dv     dif
);

  // All divider state
  typedef struct packed {
    logic [DIV_W-1:0] cnt;  // Source edges in current half period
    logic             out;  // Output level
  } rco_div_state_t;

  rco_div_state_t st_q;  // Registered state
  rco_div_state_t st_d;  // Next state

  // Last edge of the current half period
  logic last;
  assign last = (st_q.cnt == DIV_W'(dif.div - 15'h0001));

  // Period ends on the falling toggle, or every edge in pass-through
  assign dif.boundary = dif.tick & ((dif.div == '0) | (last & st_q.out));
  assign dif.out      = st_q.out;

  // Next-state logic
  always_comb begin
    st_d = st_q;
    if (!dif.run) begin
      st_d = '0;                                 // Halted output sits low
    end else if (dif.div == '0) begin
      st_d.out = dif.level;                      // Undivided pass-through
      st_d.cnt = '0;
    end else if (dif.tick) begin
      if (last) begin
        st_d.cnt = '0;                           // Half period of div edges
        st_d.out = ~st_q.out;
      end else begin
        st_d.cnt = st_q.cnt + 15'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_DIV_TOGGLE: assert property (clk_en && dif.run && dif.div != '0 && dif.tick && last
    |=> st_q.out != $past(st_q.out)) else $error("divider missed a toggle");
  AST_DIV_PASS: assert property (clk_en && dif.run && dif.div == '0
    |=> st_q.out == $past(dif.level)) else $error("pass-through broken");

endmodule // rco_divider

// ===== tb/rco_ref_partner.sv
`timescale 1ns/10ps
// Far side: makes slow source clocks and times the reference pin
module rco_ref_partner import rco_pkg::*; (
  // Clock
  input  wire logic       clk,
  // Source clocks, code i has a half period of i+2 cycles
  output logic [NSRC-1:0] src_clocks,
  // Reference pin
  input  wire logic       pin,
  input  wire logic       pin_oe_n,
  // Rising edges seen and the last period in cycles
  output int unsigned     rises,
  output int unsigned     period
);
  logic [7:0]  half_cnt [NSRC];  // Half period counters
  logic        pin_q;            // Previous driven pin level
  int unsigned since;            // Cycles since the last rise
  // Start from a quiet state
  initial begin
    src_clocks = '0;
    rises      = 0;
    period     = 0;
    since      = 0;
    pin_q      = 1'b0;
    for (int i = 0; i < NSRC; i++) half_cnt[i] = 8'h00;
  end
  // Toggle each source after its own half period
  always @(posedge clk) begin
    for (int i = 0; i < NSRC; i++) begin
      if (half_cnt[i] == 8'(i + 1)) begin
        half_cnt[i]   <= 8'h00;
        src_clocks[i] <= ~src_clocks[i];
      end else begin
        half_cnt[i] <= half_cnt[i] + 8'h01;
      end
    end
  end
  // An undriven pin counts as low; time the rising edges
  always @(posedge clk) begin
    pin_q <= pin & ~pin_oe_n;
    since <= since + 1;
    if ((pin & ~pin_oe_n) && !pin_q) begin
      rises  <= rises + 1;
      period <= since + 1;
      since  <= 0;
    end
  end
endmodule // rco_ref_partner

// ===== tb/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
// Register level tests of the reference clock generator
module testbench;
  import rco_pkg::*;
  logic              clk = 1'b0;         // 250 MHz clock
  logic              rst_n, idle_mode, sleep_mode;
  logic [NSRC-1:0]   src_clocks;         // From the far side
  logic              hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]        htrans;
  logic [31:0]       haddr, hwdata, hrdata, rv;
  logic              pin, ref_pin_oe_n;
  logic [TUNE_W-1:0] fast_rc_tune;
  logic [TRIM_W-1:0] ref_trim;
  int                err_total = 0;      // Mismatches
  int                samples_checked = 0;// Comparisons
  int unsigned       r0;                 // Rise count snapshot
  int                dv, sel, n;
  assign hready = hreadyout;  // Single slave drives the bus ready
  always #2 clk = ~clk;
  rco_refclk_gen dut_u (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .src_clocks(src_clocks), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .reference_clock_output_pin(pin), .ref_pin_oe_n(ref_pin_oe_n),
    .fast_rc_tune(fast_rc_tune), .ref_trim(ref_trim));
  rco_ref_partner far_u (.clk(clk), .src_clocks(src_clocks), .pin(pin),
    .pin_oe_n(ref_pin_oe_n), .rises(), .period());
  // Verdict and end of run
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One single AHB-Lite word transfer
  task automatic bus(input logic wr_en, input logic [31:0] a, wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr_en;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Register write and checked read
  task automatic wr(input logic [3:0] o, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, {28'h0, o}, d, x);
  endtask
  task automatic rd_chk(input logic [3:0] o, input logic [31:0] ex, input string nm);
    logic [31:0] x;
    bus(1'b0, {28'h0, o}, 32'h0, x);
    `CHK(nm, ex, x)
  endtask
  // Control word from its fields
  function automatic logic [31:0] cw(input int d, on, sd, oe, rs, sw, s);
    cw = (32'(d) << CTRL_DIV_LSB) | (32'(on) << CTRL_ON) | (32'(sd) << CTRL_STOP_IN_IDLE) |
         (32'(oe) << CTRL_OE) | (32'(rs) << CTRL_RUN_IN_SLEEP) | (32'(sw) << CTRL_SW) | 32'(s);
  endfunction
  // Pin period in clk cycles for a divider and source code
  function automatic int unsigned eper(input int d, s);
    eper = (d == 0) ? 2 * (s + 2) : 4 * d * (s + 2);
  endfunction
  // Let several periods pass, then compare the measured one
  task automatic per_chk(input int d, s);
    repeat (4 * eper(d, s) + 40) @(posedge clk);
    `CHK("period", eper(d, s), far_u.period)
  endtask
  // Check the active flag and whether the pin toggles
  task automatic act_chk(input logic ea, et, input string nm);
    repeat (10) @(posedge clk);
    r0 = far_u.rises;
    bus(1'b0, {28'h0, OFS_CTRL}, 32'h0, rv);
    `CHK(nm, ea, rv[CTRL_ACT])
    repeat (200) @(posedge clk);
    `CHK(nm, et, far_u.rises != r0)
  endtask
  // Watchdog cuts a hang short
  initial begin
    #160000;
    err_total++;
    $display("[FAIL] watchdog exp done got timeout");
    end_sim;
  end
  // Main sequence
  initial begin
    {rst_n, idle_mode, sleep_mode, hsel, hwrite} = '0;
    {htrans, haddr, hwdata} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(OFS_CTRL, REG_RST, "ctrl rst");
    rd_chk(OFS_TRIM, REG_RST, "trim rst");
    bus(1'b0, 32'h0000_0104, 32'h0, rv);
    `CHK("unmapped", 32'h0, rv)
    `CHK("hresp", HRESP_OKAY, hresp)
    `CHK("oe_n rst", 1'b1, ref_pin_oe_n)
    wr(OFS_CTRL, CTRL_RSV_MASK | (32'h1 << CTRL_ACT));
    rd_chk(OFS_CTRL, 32'h0, "ctrl rsv");
    wr(OFS_CTRL, cw(32767, 0, 0, 0, 0, 0, 0));
    rd_chk(OFS_CTRL, 32'h7fff_0000, "div field");
    wr(OFS_TUNE, 32'hffff_ffff);
    rd_chk(OFS_TUNE, 32'h0, "tune locked");
    wr(OFS_UNLK, UNLK_KEY1);
    wr(OFS_UNLK, UNLK_KEY2);
    wr(OFS_TUNE, 32'hffff_ffff);
    rd_chk(OFS_TUNE, 32'h3f, "tune");
    `CHK("tune out", 6'h3f, fast_rc_tune)
    wr(OFS_TUNE, 32'h0);
    rd_chk(OFS_TUNE, 32'h3f, "tune relock");
    wr(OFS_TRIM, 32'hffff_ffff);
    rd_chk(OFS_TRIM, 32'hff80_0000, "trim");
    `CHK("trim out", 9'h1ff, ref_trim)
    $display("test registers done");
    // Codes 0 to 8 only, then divider 0 and 2
    for (int i = 0; i < 11; i++) begin
      dv  = (i < 9) ? 1 : (i - 9) * 2;
      sel = (i < 9) ? i : 3;
      wr(OFS_CTRL, cw(dv, 0, 0, 1, 0, 0, sel));
      wr(OFS_CTRL, cw(dv, 1, 0, 1, 0, 0, sel));
      per_chk(dv, sel);
      `CHK("oe_n on", 1'b0, ref_pin_oe_n)
      wr(OFS_CTRL, cw(dv, 0, 0, 1, 0, 0, sel));
    end
    act_chk(1'b0, 1'b0, "off");
    $display("test sources done");
    wr(OFS_CTRL, cw(4, 0, 1, 1, 0, 0, 8));
    wr(OFS_CTRL, cw(4, 1, 1, 1, 0, 0, 8));
    per_chk(4, 8);
    @(posedge clk) idle_mode <= 1'b1;
    act_chk(1'b0, 1'b0, "idle stop");
    wr(OFS_TRIM, 32'h0080_0000);
    repeat (4) @(posedge clk);
    `CHK("trim held", 9'h1ff, ref_trim)
    wr(OFS_CTRL, cw(1, 1, 1, 1, 0, 0, 8));
    @(posedge clk) idle_mode <= 1'b0;
    per_chk(4, 8);
    wr(OFS_CTRL, cw(1, 1, 1, 1, 0, 1, 8));
    bus(1'b0, {28'h0, OFS_CTRL}, 32'h0, rv);
    `CHK("switch busy", 1'b1, rv[CTRL_SW])
    `CHK("trim wait", 9'h1ff, ref_trim)
    for (n = 0; n < 100 && rv[CTRL_SW] === 1'b1; n++) bus(1'b0, {28'h0, OFS_CTRL}, 32'h0, rv);
    `CHK("switch done", 1'b0, rv[CTRL_SW])
    `CHK("trim load", 9'h001, ref_trim)
    per_chk(1, 8);
    $display("test switch done");
    wr(OFS_CTRL, cw(1, 1, 0, 1, 1, 0, 8));
    @(posedge clk) sleep_mode <= 1'b1;
    act_chk(1'b1, 1'b1, "sleep run");
    @(posedge clk) sleep_mode <= 1'b0;
    wr(OFS_CTRL, cw(1, 0, 0, 1, 1, 0, 8));
    wr(OFS_CTRL, cw(1, 0, 0, 1, 1, 0, 0));
    wr(OFS_CTRL, cw(1, 1, 0, 1, 1, 0, 0));
    @(posedge clk) sleep_mode <= 1'b1;
    act_chk(1'b0, 1'b0, "sleep sys");
    @(posedge clk) sleep_mode <= 1'b0;
    wr(OFS_CTRL, cw(1, 0, 0, 1, 0, 0, 0));
    wr(OFS_CTRL, cw(1, 0, 0, 1, 0, 0, 3));
    wr(OFS_CTRL, cw(1, 1, 0, 1, 0, 0, 3));
    @(posedge clk) sleep_mode <= 1'b1;
    act_chk(1'b0, 1'b0, "sleep stop");
    wr(OFS_CTRL, cw(1, 1, 0, 1, 0, 1, 3));
    rd_chk(OFS_CTRL, cw(1, 1, 0, 1, 0, 0, 3), "halted switch");
    @(posedge clk) sleep_mode <= 1'b0;
    act_chk(1'b1, 1'b1, "wake");
    $display("test sleep done");
    wr(OFS_CTRL, cw(1, 1, 0, 0, 0, 0, 3));
    repeat (2) @(posedge clk);
    `CHK("oe_n off", 1'b1, ref_pin_oe_n)
    act_chk(1'b1, 1'b0, "pin quiet");
    wr(OFS_CTRL, cw(1, 0, 0, 0, 0, 0, 3));
    act_chk(1'b0, 1'b0, "off again");
    $display("test output done");
    end_sim;
  end
endmodule // testbench
